// file: pss_pkg.sv
package pss_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned ONE_SEC_NS     = 1_000_000_000;
  localparam int unsigned SEC_CYCLES     = ONE_SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned BEEP_HALF_NS   = 100_000_000;
  localparam int unsigned BEEP_CYCLES    = BEEP_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned BEEP_COUNT     = 3;
  localparam int unsigned SEC_PER_MIN    = 60;
  localparam int unsigned SEC_W          = 12;
  localparam int unsigned NUM_TIMERS     = 5;

  // ****************************************
  // timer slots
  // ****************************************
  localparam int unsigned T_DOZE         = 0;
  localparam int unsigned T_SLEEP        = 1;
  localparam int unsigned T_SUSP         = 2;
  localparam int unsigned T_DISK         = 3;
  localparam int unsigned T_VIDEO        = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN,
    ST_DOZE,
    ST_SLEEP,
    ST_WARN,
    ST_SUSP
  } pss_state_e;

  typedef struct packed {
    logic       pm_en;
    logic [2:0] doze_sel;
    logic [2:0] sleep_sel;
    logic [2:0] susp_sel;
    logic [2:0] disk_sel;
    logic [2:0] video_sel;
    logic [1:0] ring_sel;
    logic       beep_en;
  } pss_cfg_s;

  typedef struct packed {
    logic doze;
    logic sleep;
    logic warn;
    logic suspend;
  } pss_status_s;

  localparam pss_status_s STATUS_RST = '0;

  // ****************************************
  // setting decode, result in seconds, except ring_target which gives a ring count
  // ****************************************
  function automatic logic [SEC_W-1:0] doze_secs(input logic [2:0] s);
    case (s)
      3'h1:    doze_secs = 12'h001;
      3'h2:    doze_secs = 12'h004;
      3'h3:    doze_secs = 12'h008;
      3'h4:    doze_secs = 12'h010;
      default: doze_secs = 12'h000;
    endcase
  endfunction : doze_secs

  function automatic logic [SEC_W-1:0] mins(input logic [5:0] m);
    mins = SEC_W'(m * SEC_PER_MIN);
  endfunction : mins

  function automatic logic [SEC_W-1:0] sleep_secs(input logic [2:0] s);
    case (s)
      3'h1:    sleep_secs = mins(6'h01);
      3'h2:    sleep_secs = mins(6'h02);
      3'h3:    sleep_secs = mins(6'h04);
      3'h4:    sleep_secs = mins(6'h06);
      3'h5:    sleep_secs = mins(6'h08);
      3'h6:    sleep_secs = mins(6'h0C);
      3'h7:    sleep_secs = mins(6'h10);
      default: sleep_secs = 12'h000;
    endcase
  endfunction : sleep_secs

  function automatic logic [SEC_W-1:0] susp_secs(input logic [2:0] s);
    case (s)
      3'h1:    susp_secs = mins(6'h05);
      3'h2:    susp_secs = mins(6'h0A);
      3'h3:    susp_secs = mins(6'h0F);
      3'h4:    susp_secs = mins(6'h14);
      3'h5:    susp_secs = mins(6'h1E);
      3'h6:    susp_secs = mins(6'h28);
      3'h7:    susp_secs = mins(6'h3C);
      default: susp_secs = 12'h000;
    endcase
  endfunction : susp_secs

  function automatic logic [SEC_W-1:0] video_secs(input logic [2:0] s);
    case (s)
      3'h1:    video_secs = 12'h005;
      3'h2:    video_secs = 12'h00A;
      3'h3:    video_secs = 12'h00F;
      3'h4:    video_secs = 12'h01E;
      3'h5:    video_secs = 12'h02D;
      3'h6:    video_secs = 12'h03C;
      3'h7:    video_secs = 12'h05A;
      default: video_secs = 12'h000;
    endcase
  endfunction : video_secs

  function automatic logic [2:0] ring_target(input logic [1:0] s);
    case (s)
      2'h1:    ring_target = 3'h1;
      2'h2:    ring_target = 3'h2;
      2'h3:    ring_target = 3'h4;
      default: ring_target = 3'h0;
    endcase
  endfunction : ring_target

endpackage : pss_pkg

// file: pss_timeout.sv
`timescale 1ns/1ns
module pss_timeout
  import pss_pkg::*;
#(
  parameter int unsigned CW = SEC_W
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_b_i,
  input  wire logic          ce_i,
  input  wire logic          tick_i,
  input  wire logic          clear_i,
  input  wire logic          run_i,
  input  wire logic [CW-1:0] limit_i,
  output logic               expired_o
);

  // ****************************************
  // seconds counter
  // ****************************************
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          expired_reg;
  logic          expired_next;
  wire           step_w = run_i & tick_i & ~expired_reg;

  // counter saturates once expired, so it cannot wrap back
  assign count_next   = clear_i ? '0 : (step_w ? count_reg + 1'b1 : count_reg);
  // zero limit means disabled: never expires
  assign expired_next = ~clear_i & (limit_i != '0) & (count_next >= limit_i);
  assign expired_o    = expired_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_reg   <= '0;
      expired_reg <= 1'b0;
    end else if (ce_i) begin
      count_reg   <= count_next;
      expired_reg <= expired_next;
    end
  end

endmodule : pss_timeout

// file: pss_sequencer.sv
`timescale 1ns/1ns
// Behaviour
// - saving states entered only while master power management enable set
// - doze after selected inactivity timeout; disabled never dozes
// - from doze to sleep when selected sleep timeout expires
// - from sleep to suspend when selected suspend timeout expires
// - hard disk standby after selected disk inactivity period
// - display standby after selected display inactivity period
// - any activity brings the display back from standby
// - in suspend, wake processor after selected count of modem rings
// - warning beeps before suspend when enabled, silent otherwise
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SEC_CYCLES,
  parameter int unsigned BEEP_HALF   = BEEP_CYCLES,
  parameter int unsigned BEEPS       = BEEP_COUNT
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_b_i,
  input  wire logic  ce_i,
  input  pss_cfg_s   cfg_i,
  input  wire logic  activity_i,
  input  wire logic  disk_activity_i,
  input  wire logic  ring_i,
  output pss_status_s status_o,
  output logic       cpu_wake_o,
  output logic       disk_standby_o,
  output logic       video_standby_o,
  output logic       beep_o
);

  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned BW = $clog2(BEEP_HALF + 1);
  localparam int unsigned HW = $clog2(2 * BEEPS + 1);

  // ****************************************
  // seconds tick
  // ****************************************
  // free running: a timeout can be up to one second short
  logic [TW-1:0] tick_cnt_reg;
  wire           tick_w = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_reg <= '0;
    end else if (ce_i) begin
      tick_cnt_reg <= tick_w ? '0 : tick_cnt_reg + 1'b1;
    end
  end

  // ****************************************
  // timers
  // ****************************************
  pss_state_e state_reg;
  pss_state_e state_next;
  logic [SEC_W-1:0] limit_w [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] run_w;
  logic [NUM_TIMERS-1:0] clr_w;
  logic [NUM_TIMERS-1:0] exp_w;

  assign limit_w[T_DOZE]  = doze_secs(cfg_i.doze_sel);
  assign limit_w[T_SLEEP] = sleep_secs(cfg_i.sleep_sel);
  assign limit_w[T_SUSP]  = susp_secs(cfg_i.susp_sel);
  assign limit_w[T_DISK]  = mins({3'h0, cfg_i.disk_sel});
  assign limit_w[T_VIDEO] = video_secs(cfg_i.video_sel);

  // stage timers only run in the state they lead out of: doze timer in run, sleep in doze, suspend in sleep
  assign run_w = {2'b11, state_reg == ST_SLEEP, state_reg == ST_DOZE,
                  state_reg == ST_RUN};
  // any activity restarts every timer; disk access restarts disk timer
  assign clr_w = {NUM_TIMERS{activity_i}}
               | {1'b0, disk_activity_i, ~run_w[T_SUSP:T_DOZE]};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
      pss_timeout #(
        .CW(SEC_W)
      ) u_tmr (
        .mclk_i   (mclk_i),
        .rst_b_i  (rst_b_i),
        .ce_i     (ce_i),
        .tick_i   (tick_w),
        .clear_i  (clr_w[gi]),
        .run_i    (run_w[gi]),
        .limit_i  (limit_w[gi]),
        .expired_o(exp_w[gi])
      );
    end
  endgenerate

  // ****************************************
  // ring counting
  // ****************************************
  logic       ring_prev_reg;
  logic [2:0] ring_cnt_reg;
  wire  [2:0] ring_goal_w = ring_target(cfg_i.ring_sel);
  wire        ring_rise_w = ring_i & ~ring_prev_reg;
  wire        ring_hit_w  = (ring_goal_w != 3'h0) & ring_rise_w
                          & (ring_cnt_reg + 3'h1 == ring_goal_w);
  wire  [2:0] ring_cnt_next = (state_reg != ST_SUSP) ? 3'h0
                            : ring_cnt_reg + {2'b00, ring_rise_w};

  // ****************************************
  // warning beeps
  // ****************************************
  logic [BW-1:0] beep_cnt_reg;
  logic [HW-1:0] half_reg;
  wire           half_end_w  = (beep_cnt_reg == BW'(BEEP_HALF - 1));
  wire           beeps_done_w = half_end_w & (half_reg == HW'(2 * BEEPS - 1));
  wire           in_warn_w   = (state_reg == ST_WARN);

  // ****************************************
  // state machine
  // ****************************************
  wire quit_w = activity_i | ~cfg_i.pm_en;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (cfg_i.pm_en && !activity_i && exp_w[T_DOZE]) begin
          state_next = ST_DOZE;
        end
      end
      ST_DOZE: begin
        if (quit_w) begin
          state_next = ST_RUN;
        end else if (exp_w[T_SLEEP]) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (quit_w) begin
          state_next = ST_RUN;
        end else if (exp_w[T_SUSP]) begin
          state_next = cfg_i.beep_en ? ST_WARN : ST_SUSP;
        end
      end
      ST_WARN: begin
        if (quit_w) begin
          state_next = ST_RUN;
        end else if (beeps_done_w) begin
          state_next = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (!cfg_i.pm_en || ring_hit_w) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  pss_status_s status_next;
  assign status_next = '{doze:    state_next == ST_DOZE,
                         sleep:   state_next == ST_SLEEP,
                         warn:    state_next == ST_WARN,
                         suspend: state_next == ST_SUSP};

  // tone high on even halves only
  wire beep_next_w = (state_next == ST_WARN) & in_warn_w
                   & ~(half_end_w ? ~half_reg[0] : half_reg[0]);
  wire wake_next_w = (state_reg == ST_SUSP) & cfg_i.pm_en & ring_hit_w;
  // standby drops one cycle after activity is seen
  wire disk_next_w  = exp_w[T_DISK] & ~activity_i & ~disk_activity_i;
  wire video_next_w = exp_w[T_VIDEO] & ~activity_i;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg       <= ST_RUN;
      status_o        <= STATUS_RST;
      ring_prev_reg   <= 1'b0;
      ring_cnt_reg    <= 3'h0;
      beep_cnt_reg    <= '0;
      half_reg        <= '0;
      cpu_wake_o      <= 1'b0;
      disk_standby_o  <= 1'b0;
      video_standby_o <= 1'b0;
      beep_o          <= 1'b0;
    end else if (ce_i) begin
      state_reg       <= state_next;
      status_o        <= status_next;
      ring_prev_reg   <= ring_i;
      ring_cnt_reg    <= ring_cnt_next;
      beep_cnt_reg    <= (!in_warn_w || half_end_w) ? '0 : beep_cnt_reg + 1'b1;
      half_reg        <= !in_warn_w ? '0 : half_reg + HW'(half_end_w);
      cpu_wake_o      <= wake_next_w;
      disk_standby_o  <= disk_next_w;
      video_standby_o <= video_next_w;
      beep_o          <= beep_next_w;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_pm_off;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && !cfg_i.pm_en) |=> (state_reg == ST_RUN) && !status_o.suspend;
  endproperty
  a_pm_off: assert property (p_pm_off) else $error("saving state with pm off");

  property p_doze;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && state_reg == ST_RUN && cfg_i.pm_en && !activity_i
      && exp_w[T_DOZE]) |=> status_o.doze;
  endproperty
  a_doze: assert property (p_doze) else $error("doze not entered");

  property p_doze_off;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == ST_RUN && cfg_i.doze_sel == 3'h0) |=> !status_o.doze;
  endproperty
  a_doze_off: assert property (p_doze_off) else $error("doze while off");

  property p_sleep;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && state_reg == ST_DOZE && !quit_w && exp_w[T_SLEEP])
      |=> status_o.sleep && !status_o.doze;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_susp;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && state_reg == ST_SLEEP && !quit_w && exp_w[T_SUSP])
      |=> (cfg_i.beep_en ? status_o.warn : status_o.suspend);
  endproperty
  a_susp: assert property (p_susp) else $error("suspend step wrong");

  property p_disk;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && disk_activity_i) |=> !disk_standby_o ##1 !exp_w[T_DISK];
  endproperty
  a_disk: assert property (p_disk) else $error("disk standby kept");

  property p_video;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && exp_w[T_VIDEO] && !activity_i) |=> video_standby_o;
  endproperty
  a_video: assert property (p_video) else $error("video standby late");

  property p_video_wake;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && video_standby_o && activity_i) |=> !video_standby_o;
  endproperty
  a_video_wake: assert property (p_video_wake) else $error("no wake");

  property p_ring;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && state_reg == ST_SUSP && cfg_i.pm_en && ring_hit_w)
      |=> cpu_wake_o && state_reg == ST_RUN;
  endproperty
  a_ring: assert property (p_ring) else $error("ring wake missed");

  property p_beep;
    @(posedge mclk_i) disable iff (!rst_b_i)
    beep_o |-> status_o.warn && cfg_i.beep_en;
  endproperty
  a_beep: assert property (p_beep) else $error("beep outside warning");

  property p_wake;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && activity_i && (status_o.doze || status_o.sleep))
      |=> !status_o.doze && !status_o.sleep && (exp_w == '0);
  endproperty
  a_wake: assert property (p_wake) else $error("activity ignored");

endmodule : pss_sequencer

// file: pss_far_model.sv
`timescale 1ns/1ns
// ****************************************
// modem ring source
// ****************************************
module pss_far_model
  import pss_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] n_i,
  output logic            ring_o,
  output logic            busy_o
);
  logic [4:0] cnt_reg = 5'h00;

  // four cycles a ring, so every ring is a clean 0->1 at the sampler
  always_ff @(posedge mclk_i) begin
    if (go_i) begin
      cnt_reg <= {n_i, 2'b00};
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
  // line idles low between rings
  assign ring_o = cnt_reg[1];
  assign busy_o = cnt_reg != 5'h00;
endmodule : pss_far_model

// file: pss_sequencer_tb_top.sv
`timescale 1ns/1ns
module pss_sequencer_tb_top
  import pss_pkg::*;
;
  // ****************************************
  // setup
  // ****************************************
  localparam int T = 4;
  localparam int BH = 3;
  localparam int BN = 2;
  localparam logic [3:0] S_RUN = 4'h0, S_DOZE = 4'h8, S_SLEEP = 4'h4;
  localparam logic [3:0] S_WARN = 4'h2, S_SUSP = 4'h1;
  int dz [8] = '{0, 1, 4, 8, 16, 0, 0, 0};
  int sl [8] = '{0, 60, 120, 240, 360, 480, 720, 960};
  int su [8] = '{0, 300, 600, 900, 1200, 1800, 2400, 3600};
  int vd [8] = '{0, 5, 10, 15, 30, 45, 60, 90};
  logic        mclk_i, rst_b_i, activity_i, disk_activity_i, ring_i;
  logic        go, busy, wake, disk_sb, vid_sb, beep, beep_d, ce;
  logic [2:0]  rn;
  pss_cfg_s    cfg;
  pss_status_s status;
  logic [6:0]  exp_q [$];
  logic [6:0]  prev = 7'h00;
  logic [6:0]  cur = 7'h00;
  int fails = 0, checks_done = 0, cyc = 0, mark = 0, beeps = 0;
  int b, lo, hi, seed;

  pss_sequencer #(.TICK_CYCLES(T), .BEEP_HALF(BH), .BEEPS(BN))
    i_pss_sequencer (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce),
      .cfg_i(cfg), .activity_i(activity_i),
      .disk_activity_i(disk_activity_i), .ring_i(ring_i),
      .status_o(status), .cpu_wake_o(wake), .disk_standby_o(disk_sb),
      .video_standby_o(vid_sb), .beep_o(beep));
  pss_far_model i_pss_far_model (.mclk_i(mclk_i), .go_i(go), .n_i(rn),
    .ring_o(ring_i), .busy_o(busy));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ****************************************
  // output watcher
  // ****************************************
  always begin
    @(posedge mclk_i);
    #2;
    cyc++;
    cur = {status, disk_sb, vid_sb, wake};
    if (rst_b_i && cur !== prev) begin
      if (exp_q.size() == 0) chk_vec("unexpected", prev, cur);
      else chk_vec("outputs", exp_q.pop_front(), cur);
    end
    prev = cur;
    if (beep === 1'b1 && beep_d !== 1'b1) beeps++;
    beep_d = beep;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk_vec(input string n, input logic [6:0] e,
                         input logic [6:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_vec

  task automatic chk_int(input string n, input int e, input int g);
    checks_done++;
    if (g != e) begin
      fails++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_int

  // window is counted from mark, not from the call
  task automatic wait_q(input int l, input int h);
    while (cyc - mark < l) @(negedge mclk_i);
    chk_int("early", 1, int'(exp_q.size() != 0));
    while (exp_q.size() != 0 && cyc - mark <= h) @(negedge mclk_i);
    chk_int("late", 0, exp_q.size());
    exp_q.delete();
  endtask : wait_q

  task automatic expect_chg(input logic [6:0] v, input int l, input int h);
    exp_q.push_back(v);
    wait_q(l, h);
  endtask : expect_chg

  task automatic go_active(input logic [6:0] v);
    exp_q.push_back(v);
    activity_i = 1'b1;
    mark = cyc;
    wait_q(0, 3);
  endtask : go_active

  task automatic idle();
    activity_i = 1'b0;
    mark = cyc;
  endtask : idle

  task automatic ring(input logic [2:0] n);
    rn = n;
    go = 1'b1;
    @(negedge mclk_i);
    go = 1'b0;
    for (int i = 0; i < 40 && busy; i++) @(negedge mclk_i);
    repeat (3) @(negedge mclk_i);
  endtask : ring

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #(900_000);
    fails++;
    $display("[FAIL] watchdog expected end seen hang");
    complete_run();
  end

  initial begin
    rst_b_i = 1'b0;
    activity_i = 1'b1;
    disk_activity_i = 1'b0;
    go = 1'b0;
    rn = 3'h0;
    ce = 1'b1;
    cfg = '0;
    seed = $urandom(32'hddc6);
    repeat (3) @(negedge mclk_i);
    rst_b_i = 1'b1;
    chk_vec("reset", 7'h00, {status, disk_sb, vid_sb, wake});
    cfg.doze_sel = 3'h1;
    idle();
    repeat (60) @(negedge mclk_i);
    chk_vec("pm off", 7'h00, cur);
    activity_i = 1'b1;
    $display("test pm_off done");
    // doze timer is still expired here, so only a frozen fsm stays in run
    ce = 1'b0;
    cfg.pm_en = 1'b1;
    idle();
    repeat (40) @(negedge mclk_i);
    chk_vec("ce low", 7'h00, cur);
    ce = 1'b1;
    activity_i = 1'b1;
    $display("test ce done");
    cfg.pm_en = 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(negedge mclk_i);
      cfg.doze_sel = 3'(c);
      idle();
      if (dz[c] == 0) begin
        repeat (80) @(negedge mclk_i);
        chk_vec("doze off", 7'h00, cur);
        activity_i = 1'b1;
      end else begin
        expect_chg({S_DOZE, 3'h0}, (dz[c] - 1) * T, dz[c] * T + 4);
        go_active(7'h00);
      end
    end
    $display("test doze done");
    cfg.doze_sel = 3'h1;
    for (int c = 0; c < 8; c++) begin
      @(negedge mclk_i);
      cfg.sleep_sel = 3'(c);
      idle();
      expect_chg({S_DOZE, 3'h0}, 0, 8);
      mark = cyc;
      if (sl[c] == 0) begin
        repeat (300) @(negedge mclk_i);
        chk_vec("sleep off", {S_DOZE, 3'h0}, cur);
      end else begin
        expect_chg({S_SLEEP, 3'h0}, (sl[c] - 1) * T, sl[c] * T + 4);
      end
      go_active(7'h00);
    end
    $display("test sleep done");
    cfg.sleep_sel = 3'h1;
    for (int c = 0; c < 8; c++) begin
      @(negedge mclk_i);
      cfg.susp_sel = 3'(c);
      cfg.beep_en = 1'($urandom % 2);
      cfg.ring_sel = 2'(c % 4);
      idle();
      expect_chg({S_DOZE, 3'h0}, 0, 8);
      mark = cyc;
      expect_chg({S_SLEEP, 3'h0}, 59 * T, 60 * T + 4);
      mark = cyc;
      b = beeps;
      if (su[c] == 0) begin
        repeat (300) @(negedge mclk_i);
        chk_vec("suspend off", {S_SLEEP, 3'h0}, cur);
        go_active(7'h00);
        continue;
      end
      lo = (su[c] - 1) * T;
      hi = su[c] * T + 4;
      if (cfg.beep_en) begin
        expect_chg({S_WARN, 3'h0}, lo, hi);
        mark = cyc;
        lo = 0;
        hi = 2 * BH * BN + 8;
      end
      expect_chg({S_SUSP, 3'h0}, lo, hi);
      chk_int("beeps", cfg.beep_en ? BN : 0, beeps - b);
      activity_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      activity_i = 1'b0;
      if (cfg.ring_sel == 2'h0) begin
        ring(3'h4);
        chk_vec("ring off", {S_SUSP, 3'h0}, cur);
        cfg.pm_en = 1'b0;
        mark = cyc;
        expect_chg({S_RUN, 3'h0}, 0, 3);
        activity_i = 1'b1;
        cfg.pm_en = 1'b1;
      end else begin
        ring(3'((1 << cfg.ring_sel) >> 1) - 3'h1);
        chk_vec("rings short", {S_SUSP, 3'h0}, cur);
        exp_q.push_back({S_RUN, 3'h1});
        exp_q.push_back({S_RUN, 3'h0});
        mark = cyc;
        // launch only: the wake shows while the ring is still running
        rn = 3'h1;
        go = 1'b1;
        @(negedge mclk_i);
        go = 1'b0;
        wait_q(0, 12);
        activity_i = 1'b1;
      end
    end
    $display("test suspend done");
    for (int d = 1; d < 8; d++) begin
      @(negedge mclk_i);
      cfg = '0;
      cfg.video_sel = 3'(d);
      cfg.disk_sel = 3'(d);
      idle();
      expect_chg({S_RUN, 3'h2}, (vd[d] - 1) * T, vd[d] * T + 4);
      expect_chg({S_RUN, 3'h6}, (d * 60 - 1) * T, d * 240 + 4);
      exp_q.push_back({S_RUN, 3'h2});
      disk_activity_i = 1'b1;
      mark = cyc;
      wait_q(0, 3);
      disk_activity_i = 1'b0;
      @(negedge mclk_i);
      go_active(7'h00);
    end
    $display("test standby done");
    @(negedge mclk_i);
    complete_run();
  end
endmodule : pss_sequencer_tb_top
